// File: fbis_boot_ctrl.sv
// What this block does
// - During reset the init-done line is released, pulled high outside.
// - Line stays released after reset until the flash boot copy finishes.
// - After boot, drive the line high while auto-initialisation still runs.
// - Drive the line low when auto-initialisation finishes; falling edge means done.
// - Host commands and video are accepted only after the init-done falling edge.
// - Initialisation typically ends within 500 ms of reset release.
// - Flash addresses are 24 bits, covering up to 16 MB.
// - Flash accesses start at about 1.39 MHz, then run at 25 MHz.
// - Two independent active-low chip selects share one serial flash link.
// - Boot code is fetched from the flash on chip select zero.
// - Boot copies flash code into program memory, then hands over to initialisation.
// - One data line each way, conventional serial flash command protocol.
// - Serial link uses clock polarity and phase mode 0.
// - Boot sends write enable, polls status for the latch, writes status zero.
// - Every program or erase is preceded by write enable and latch polling.
// - Same commands and clock rates whatever flash part is attached.
`timescale 1ns/1ps
module fbis_boot_ctrl
  import fbis_pkg::*;
#(
  parameter int unsigned INIT_LIMIT_CYC = INIT_TYP_CYC
)
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  output logic                     flash_sck,
  output logic                     flash_mosi,
  input  wire logic                flash_miso,
  output logic                     boot_flash_select_n,
  output logic                     aux_flash_select_n,
  output logic                     init_done_o,
  output logic                     init_done_oe,
  output logic                     pmem_we,
  output logic [PMEM_AW-1:0]       pmem_addr,
  output logic [7:0]               pmem_data,
  input  wire logic                auto_init_done,
  input  wire logic                flash_req,
  input  wire logic                flash_req_erase,
  input  wire logic                flash_req_cs,
  input  wire logic [FLASH_AW-1:0] flash_req_addr,
  input  wire logic [7:0]          flash_req_data,
  output logic                     flash_req_ready,
  output logic                     host_access_open,
  output logic                     init_late
);

  fbis_state_e           state_q, state_d;
  logic [2:0]            idx_q, idx_d;
  logic                  pend_q, pend_d;
  logic                  op_q, op_d;
  logic                  fast_q, fast_d;
  logic                  erase_q, erase_d;
  logic                  cs_q, cs_d;
  logic [FLASH_AW-1:0]   addr_q, addr_d;
  logic [7:0]            wdata_q, wdata_d;
  logic [PMEM_AW-1:0]    cnt_q, cnt_d;
  logic                  pmem_we_q, pmem_we_d;
  logic [PMEM_AW-1:0]    pmem_addr_q, pmem_addr_d;
  logic [7:0]            pmem_data_q, pmem_data_d;
  logic                  irq_o_q, irq_o_d;
  logic                  irq_oe_q, irq_oe_d;
  logic                  ready_q, ready_d;
  logic                  open_q, open_d;
  logic [31:0]           late_cnt_q, late_cnt_d;
  logic                  late_q, late_d;
  logic                  miso_meta_q;
  logic                  miso_sync_q;

  logic                  eng_ready;
  logic                  eng_done;
  logic [7:0]            eng_rx;
  logic [1:0]            eng_cs_n;
  logic                  issue;
  logic [7:0]            cur_tx;
  logic                  cur_last;
  logic                  link_state;

  // Two flops before anything reads the pin
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miso_meta_q <= 1'b0;
      miso_sync_q <= 1'b0;
    end
    else
    begin
      miso_meta_q <= flash_miso;
      miso_sync_q <= miso_meta_q;
    end
  end

  // Byte to send for the current state and position inside the command
  always_comb
  begin
    cur_tx   = DUMMY_BYTE;
    cur_last = 1'b0;
    case (state_q)
      S_WRITE_ENABLE_CMD:
      begin
        cur_tx   = WRITE_ENABLE_CMD;
        cur_last = 1'b1;
      end
      S_STATUS_READ_CMD:
      begin
        cur_tx   = (idx_q == IDX_FIRST) ? STATUS_READ_CMD : DUMMY_BYTE;
        cur_last = (idx_q != IDX_FIRST);
      end
      S_STATUS_WRITE_CMD:
      begin
        cur_tx   = (idx_q == IDX_FIRST) ? STATUS_WRITE_CMD : STATUS_CLEAR;
        cur_last = (idx_q != IDX_FIRST);
      end
      S_FREAD:
      begin
        case (idx_q)
          3'h0:    cur_tx = FAST_READ_CMD;
          3'h1:    cur_tx = addr_q[23:16];
          3'h2:    cur_tx = addr_q[15:8];
          3'h3:    cur_tx = addr_q[7:0];
          default: cur_tx = DUMMY_BYTE;
        endcase
        cur_last = (idx_q == IDX_DATA) && (cnt_q == BOOT_LAST);
      end
      S_OP:
      begin
        case (idx_q)
          3'h0:    cur_tx = erase_q ? SECTOR_ERASE_CMD : PAGE_PROGRAM_CMD;
          3'h1:    cur_tx = addr_q[23:16];
          3'h2:    cur_tx = addr_q[15:8];
          3'h3:    cur_tx = addr_q[7:0];
          default: cur_tx = wdata_q;
        endcase
        cur_last = erase_q ? (idx_q == 3'h3) : (idx_q == IDX_DUMMY);
      end
      default:
      begin
        cur_tx   = DUMMY_BYTE;
        cur_last = 1'b0;
      end
    endcase
  end

  assign link_state = (state_q != S_RUN) && (state_q != S_DONE);
  assign issue      = link_state && eng_ready && !pend_q;

  always_comb
  begin
    state_d     = state_q;
    idx_d       = idx_q;
    pend_d      = pend_q;
    op_d        = op_q;
    fast_d      = fast_q;
    erase_d     = erase_q;
    cs_d        = cs_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    cnt_d       = cnt_q;
    pmem_we_d   = 1'b0;
    pmem_addr_d = pmem_addr_q;
    pmem_data_d = pmem_data_q;
    irq_o_d     = irq_o_q;
    irq_oe_d    = irq_oe_q;
    open_d      = open_q;
    late_cnt_d  = late_cnt_q;
    late_d      = late_q;

    if (issue)
      pend_d = 1'b1;

    if (eng_done)
    begin
      pend_d = 1'b0;
      case (state_q)
        S_WRITE_ENABLE_CMD:
        begin
          idx_d   = IDX_FIRST;
          state_d = S_STATUS_READ_CMD;
        end
        S_STATUS_READ_CMD:
        begin
          if (idx_q == IDX_FIRST)
            idx_d = 3'h1;
          else
          begin
            idx_d = IDX_FIRST;
            // Keep polling until the flash reports its latch set
            if (eng_rx[WRITE_ENABLE_LATCH_BIT])
              state_d = op_q ? S_OP : S_STATUS_WRITE_CMD;
          end
        end
        S_STATUS_WRITE_CMD:
        begin
          if (idx_q == IDX_FIRST)
            idx_d = 3'h1;
          else
          begin
            idx_d   = IDX_FIRST;
            fast_d  = 1'b1;
            addr_d  = BOOT_FLASH_BASE;
            state_d = S_FREAD;
          end
        end
        S_FREAD:
        begin
          if (idx_q != IDX_DATA)
            idx_d = idx_q + 3'h1;
          else
          begin
            pmem_we_d   = 1'b1;
            pmem_addr_d = cnt_q;
            pmem_data_d = eng_rx;
            cnt_d       = cnt_q + 12'h001;
            if (cnt_q == BOOT_LAST)
            begin
              idx_d    = IDX_FIRST;
              irq_o_d  = 1'b1;
              irq_oe_d = 1'b1;
              state_d  = S_RUN;
            end
          end
        end
        S_OP:
        begin
          if (cur_last)
          begin
            // Latch clears itself in the flash, so each request re-enables
            idx_d   = IDX_FIRST;
            state_d = S_RUN;
          end
          else
            idx_d = idx_q + 3'h1;
        end
        default:
          state_d = state_q;
      endcase
    end

    case (state_q)
      S_RUN:
      begin
        if (auto_init_done)
        begin
          irq_o_d = 1'b0;
          open_d  = 1'b1;
          state_d = S_DONE;
        end
        else if (flash_req && ready_q)
        begin
          op_d    = 1'b1;
          erase_d = flash_req_erase;
          cs_d    = flash_req_cs;
          addr_d  = flash_req_addr;
          wdata_d = flash_req_data;
          idx_d   = IDX_FIRST;
          state_d = S_WRITE_ENABLE_CMD;
        end
      end
      S_DONE:
        state_d = S_DONE;
      default:
        state_d = state_d;
    endcase

    if (!open_q && !late_q)
    begin
      // Flag only; the nominal time is typical, not a hard limit
      if (late_cnt_q >= INIT_LIMIT_CYC - 1)
        late_d = 1'b1;
      else
        late_cnt_d = late_cnt_q + 32'h0000_0001;
    end
  end

  // Hold requests off until the engine has finished its select gap
  assign ready_d = (state_d == S_RUN) && eng_ready;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= S_WRITE_ENABLE_CMD;
      idx_q       <= IDX_FIRST;
      pend_q      <= 1'b0;
      op_q        <= 1'b0;
      fast_q      <= 1'b0;
      erase_q     <= 1'b0;
      cs_q        <= BOOT_CS;
      addr_q      <= BOOT_FLASH_BASE;
      wdata_q     <= 8'h00;
      cnt_q       <= 12'h000;
      pmem_we_q   <= 1'b0;
      pmem_addr_q <= 12'h000;
      pmem_data_q <= 8'h00;
      irq_o_q     <= 1'b0;
      irq_oe_q    <= 1'b0;
      ready_q     <= 1'b0;
      open_q      <= 1'b0;
      late_cnt_q  <= 32'h0000_0000;
      late_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      pend_q      <= pend_d;
      op_q        <= op_d;
      fast_q      <= fast_d;
      erase_q     <= erase_d;
      cs_q        <= cs_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      cnt_q       <= cnt_d;
      pmem_we_q   <= pmem_we_d;
      pmem_addr_q <= pmem_addr_d;
      pmem_data_q <= pmem_data_d;
      irq_o_q     <= irq_o_d;
      irq_oe_q    <= irq_oe_d;
      ready_q     <= ready_d;
      open_q      <= open_d;
      late_cnt_q  <= late_cnt_d;
      late_q      <= late_d;
    end
  end

  fbis_spi_engine u_engine (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .start     (issue),
    .last      (cur_last),
    .fast      (fast_q),
    .cs_sel    (cs_q),
    .tx_byte   (cur_tx),
    .miso_sync (miso_sync_q),
    .ready     (eng_ready),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .sck       (flash_sck),
    .mosi      (flash_mosi),
    .cs_n      (eng_cs_n)
  );

  assign boot_flash_select_n = eng_cs_n[0];
  assign aux_flash_select_n  = eng_cs_n[1];
  assign init_done_o         = irq_o_q;
  assign init_done_oe        = irq_oe_q;
  assign pmem_we             = pmem_we_q;
  assign pmem_addr           = pmem_addr_q;
  assign pmem_data           = pmem_data_q;
  assign flash_req_ready     = ready_q;
  assign host_access_open    = open_q;
  assign init_late           = late_q;

endmodule : fbis_boot_ctrl

// File: fbis_pkg.sv
package fbis_pkg;

  localparam int unsigned CLK_KHZ        = 100000;
  localparam int unsigned CLK_PERIOD_NS  = 10;

  localparam int unsigned SCK_SLOW_KHZ   = 1420;
  localparam int unsigned SCK_FAST_KHZ   = 30000;
  // Half periods round up so the serial clock never exceeds its nominal rate
  localparam logic [7:0]  SCK_SLOW_HALF  =
    8'((CLK_KHZ + 2 * SCK_SLOW_KHZ - 1) / (2 * SCK_SLOW_KHZ));
  localparam logic [7:0]  SCK_FAST_HALF  =
    8'((CLK_KHZ + 2 * SCK_FAST_KHZ - 1) / (2 * SCK_FAST_KHZ));

  localparam int unsigned CS_HIGH_NS     = 200;
  localparam logic [7:0]  CS_GAP_CYC     =
    8'((CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int unsigned INIT_TYP_MS    = 500;
  localparam int unsigned INIT_TYP_CYC   = INIT_TYP_MS * CLK_KHZ;

  localparam logic [7:0]  FAST_READ_CMD    = 8'h0B;
  localparam logic [7:0]  STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0]  STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0]  WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0]  PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0]  SECTOR_ERASE_CMD = 8'h20;
  localparam logic [7:0]  DUMMY_BYTE       = 8'h00;
  localparam logic [7:0]  STATUS_CLEAR     = 8'h00;
  localparam int unsigned WRITE_ENABLE_LATCH_BIT = 1;

  localparam int unsigned FLASH_AW        = 24;
  localparam int unsigned PMEM_AW         = 12;
  localparam logic [23:0] BOOT_FLASH_BASE = 24'h00_0000;
  // Image kept short so a full boot copy stays quick to exercise
  localparam logic [11:0] BOOT_LAST       = 12'h3FF;
  localparam logic        BOOT_CS         = 1'h0;

  localparam logic [2:0]  IDX_FIRST       = 3'h0;
  localparam logic [2:0]  IDX_DUMMY       = 3'h4;
  localparam logic [2:0]  IDX_DATA        = 3'h5;

  typedef enum logic [2:0] {
    S_WRITE_ENABLE_CMD  = 3'b000,
    S_STATUS_READ_CMD  = 3'b001,
    S_STATUS_WRITE_CMD  = 3'b010,
    S_FREAD = 3'b011,
    S_RUN   = 3'b100,
    S_OP    = 3'b101,
    S_DONE  = 3'b110
  } fbis_state_e;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_LOW  = 2'b01,
    E_HIGH = 2'b10,
    E_GAP  = 2'b11
  } fbis_eng_e;

endpackage : fbis_pkg

// File: fbis_spi_engine.sv
`timescale 1ns/1ps
module fbis_spi_engine
  import fbis_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       last,
  input  wire logic       fast,
  input  wire logic       cs_sel,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso_sync,
  output logic            ready,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            sck,
  output logic            mosi,
  output logic [1:0]      cs_n
);

  fbis_eng_e   st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [7:0]  half_q, half_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  rx_q, rx_d;
  logic        last_q, last_d;
  logic        sck_q, sck_d;
  logic        mosi_q, mosi_d;
  logic [1:0]  cs_n_q, cs_n_d;
  logic        done_q, done_d;
  logic        ready_q, ready_d;

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    half_d  = half_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    rx_d    = rx_q;
    last_d  = last_q;
    sck_d   = sck_q;
    mosi_d  = mosi_q;
    cs_n_d  = cs_n_q;
    done_d  = 1'b0;
    ready_d = ready_q;
    case (st_q)
      E_IDLE:
      begin
        if (start)
        begin
          cs_n_d  = cs_sel ? 2'h1 : 2'h2;
          sh_d    = tx_byte;
          mosi_d  = tx_byte[7];
          bit_d   = 3'h7;
          half_d  = fast ? SCK_FAST_HALF : SCK_SLOW_HALF;
          cnt_d   = fast ? SCK_FAST_HALF : SCK_SLOW_HALF;
          last_d  = last;
          ready_d = 1'b0;
          st_d    = E_LOW;
        end
      end
      E_LOW:
      begin
        if (cnt_q == 8'h01)
        begin
          sck_d = 1'b1;
          cnt_d = half_q;
          st_d  = E_HIGH;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      E_HIGH:
      begin
        if (cnt_q == 8'h01)
        begin
          // Sampled late in the high phase so the synchroniser delay is covered
          sh_d  = {sh_q[6:0], miso_sync};
          sck_d = 1'b0;
          if (bit_q == 3'h0)
          begin
            rx_d   = {sh_q[6:0], miso_sync};
            done_d = 1'b1;
            if (last_q)
            begin
              cs_n_d = 2'h3;
              cnt_d  = CS_GAP_CYC;
              st_d   = E_GAP;
            end
            else
            begin
              ready_d = 1'b1;
              st_d    = E_IDLE;
            end
          end
          else
          begin
            bit_d  = bit_q - 3'h1;
            mosi_d = sh_q[6];
            cnt_d  = half_q;
            st_d   = E_LOW;
          end
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      E_GAP:
      begin
        if (cnt_q == 8'h01)
        begin
          ready_d = 1'b1;
          st_d    = E_IDLE;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      default:
        st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q    <= E_IDLE;
      cnt_q   <= 8'h00;
      half_q  <= 8'h00;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      rx_q    <= 8'h00;
      last_q  <= 1'b0;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      cs_n_q  <= 2'h3;
      done_q  <= 1'b0;
      ready_q <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      half_q  <= half_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      rx_q    <= rx_d;
      last_q  <= last_d;
      sck_q   <= sck_d;
      mosi_q  <= mosi_d;
      cs_n_q  <= cs_n_d;
      done_q  <= done_d;
      ready_q <= ready_d;
    end
  end

  assign ready   = ready_q;
  assign done    = done_q;
  assign rx_byte = rx_q;
  assign sck     = sck_q;
  assign mosi    = mosi_q;
  assign cs_n    = cs_n_q;

endmodule : fbis_spi_engine

// File: fbis_flash_model.sv
`timescale 1ns/1ps
module fbis_flash_model
  import fbis_pkg::*;
(
  input  wire logic   rst_n,
  input  wire logic   sck,
  input  wire logic   mosi,
  input  wire logic   cs_n,
  output logic        miso,
  output int          cnt [0:5],
  output logic [7:0]  first_op,
  output logic [7:0]  last_data,
  output logic [23:0] last_addr
);
  // cnt: write enable, status poll, status write, program, erase, fault
  logic [7:0]  sh_q;
  logic [7:0]  op_q;
  logic [7:0]  tx_q;
  logic [23:0] addr_q;
  logic        write_enable_latch;
  int          bit_n;
  int          polls;
  int          k;

  function automatic logic [7:0] img(input logic [23:0] a);
    return a[7:0] ^ {4'h0, a[11:8]} ^ 8'h5A;
  endfunction : img

  always @(negedge cs_n or negedge rst_n)
    if (!rst_n)
    begin
      cnt = '{default: 0};
      write_enable_latch = 1'b0;
      miso = 1'b1;
    end
    else
    begin
      bit_n = 0;
      if (sck)
        cnt[5]++;
    end

  // Timing-agnostic, so slow and fast rates both work
  always @(posedge sck)
    if (!cs_n)
    begin
      sh_q = {sh_q[6:0], mosi};
      bit_n++;
      k = bit_n / 8;
      if (bit_n % 8 == 0)
      begin
        if (k == 1)
        begin
          if (cnt[0] == 0)
            first_op = sh_q;
          op_q = sh_q;
          if (sh_q == WRITE_ENABLE_CMD)
          begin
            write_enable_latch = 1'b1;
            polls = 0;
            cnt[0]++;
          end
          if (sh_q == STATUS_READ_CMD)
          begin
            polls++;
            cnt[1]++;
            // Latch shows only from the second poll, forcing a retry
            tx_q = {6'h00, write_enable_latch && polls > 1, 1'b0};
          end
        end
        else if (op_q == STATUS_WRITE_CMD && k == 2)
        begin
          last_data = sh_q;
          cnt[2]++;
          write_enable_latch = 1'b0;
        end
        else if (k <= 4)
          addr_q = {addr_q[15:0], sh_q};
        else if (op_q == FAST_READ_CMD && k > 5)
          addr_q = addr_q + 24'h00_0001;
        if (op_q == FAST_READ_CMD && k >= 4)
          tx_q = img(addr_q);
        if ((op_q == PAGE_PROGRAM_CMD && k == 5) || (op_q == SECTOR_ERASE_CMD && k == 4))
        begin
          if (op_q == PAGE_PROGRAM_CMD)
            last_data = sh_q;
          cnt[op_q == PAGE_PROGRAM_CMD ? 3 : 4]++;
          if (!write_enable_latch)
            cnt[5]++;
          last_addr = addr_q;
          write_enable_latch = 1'b0;
        end
      end
    end

  always @(negedge sck)
    if (!cs_n)
      miso = tx_q[7 - bit_n % 8];

  // Released line shows the inverse, never a stale level
  always @(posedge cs_n)
    miso = ~miso;
endmodule : fbis_flash_model

// File: fbis_boot_monitor.sv
`timescale 1ns/1ps
module fbis_boot_monitor
  import fbis_pkg::*;
#(
  parameter int unsigned INIT_LIMIT_CYC = INIT_TYP_CYC
)
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                flash_sck,
  input wire logic                flash_mosi,
  input wire logic                flash_miso,
  input wire logic                boot_flash_select_n,
  input wire logic                aux_flash_select_n,
  input wire logic                init_done_o,
  input wire logic                init_done_oe,
  input wire logic                pmem_we,
  input wire logic [PMEM_AW-1:0]  pmem_addr,
  input wire logic [7:0]          pmem_data,
  input wire logic                auto_init_done,
  input wire logic                flash_req,
  input wire logic                flash_req_erase,
  input wire logic                flash_req_cs,
  input wire logic [FLASH_AW-1:0] flash_req_addr,
  input wire logic [7:0]          flash_req_data,
  input wire logic                flash_req_ready,
  input wire logic                host_access_open,
  input wire logic                init_late
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic               rst_seen_q;
  logic [7:0]         hi_cnt_q;
  logic [7:0]         hi_cnt_d;
  logic               fell_q;
  logic               fell_d;
  logic               we_seen_q;
  logic               we_seen_d;
  logic [PMEM_AW-1:0] last_q;
  logic [PMEM_AW-1:0] last_d;

  always_comb
  begin
    hi_cnt_d  = flash_sck ? hi_cnt_q + 8'h01 : 8'h00;
    fell_d    = fell_q | (hi_cnt_q != 8'h00 && !flash_sck);
    we_seen_d = we_seen_q | pmem_we;
    last_d    = pmem_we ? pmem_addr : last_q;
  end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      hi_cnt_q  <= 8'h00;
      fell_q    <= 1'b0;
      we_seen_q <= 1'b0;
      last_q    <= '0;
    end
    else
    begin
      hi_cnt_q  <= hi_cnt_d;
      fell_q    <= fell_d;
      we_seen_q <= we_seen_d;
      last_q    <= last_d;
    end

  // No reset here, so the first edge of a reset, before outputs settle, is skipped
  always_ff @(posedge core_clk)
    rst_seen_q <= !rst_n;

  sequence s_finish;
    init_done_oe && init_done_o && auto_init_done;
  endsequence
  sequence s_open;
    init_done_oe && !init_done_o && host_access_open;
  endsequence

  property p_reset_idle;
    disable iff (1'b0)
    !rst_n && rst_seen_q |->
      !init_done_oe && boot_flash_select_n && aux_flash_select_n && !flash_sck;
  endproperty
  property p_copy_released; pmem_we |-> init_done_oe == (pmem_addr == BOOT_LAST); endproperty
  property p_drive_high; $rose(init_done_oe) |-> init_done_o; endproperty
  property p_finish; s_finish |=> s_open; endproperty
  property p_cs_single; !boot_flash_select_n |-> aux_flash_select_n; endproperty
  property p_sck_idle; boot_flash_select_n && aux_flash_select_n |-> !flash_sck; endproperty
  property p_cs_gap; $rose(boot_flash_select_n) |-> boot_flash_select_n [*8]; endproperty
  property p_half;
    $fell(flash_sck) |-> hi_cnt_q == SCK_SLOW_HALF || hi_cnt_q == SCK_FAST_HALF;
  endproperty
  property p_first_slow; $fell(flash_sck) && !fell_q |-> hi_cnt_q == SCK_SLOW_HALF; endproperty
  property p_pmem_order;
    pmem_we |-> pmem_addr == (we_seen_q ? PMEM_AW'(last_q + 1'b1) : '0);
  endproperty
  property p_req_taken;
    flash_req && flash_req_ready && !auto_init_done |=> !flash_req_ready ##[0:2]
      (!boot_flash_select_n || !aux_flash_select_n);
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");
  a_copy_released: assert property (p_copy_released) else $error("line driven in boot");
  a_drive_high: assert property (p_drive_high) else $error("line not driven high");
  a_finish: assert property (p_finish) else $error("init done not signalled");
  a_cs_single: assert property (p_cs_single) else $error("both selects low");
  a_sck_idle: assert property (p_sck_idle) else $error("clock high while idle");
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  a_half: assert property (p_half) else $error("clock half period wrong");
  a_first_slow: assert property (p_first_slow) else $error("first access not slow");
  a_pmem_order: assert property (p_pmem_order) else $error("copy address order");
  a_req_taken: assert property (p_req_taken) else $error("request not started");
endmodule : fbis_boot_monitor

bind fbis_boot_ctrl fbis_boot_monitor #(.INIT_LIMIT_CYC(INIT_LIMIT_CYC)) mon_u (.*);

// File: tb_flash_boot_and_init_signal.sv
`timescale 1ns/1ps
module tb_flash_boot_and_init_signal;
  import fbis_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, auto_init_done = 1'b0, flash_req = 1'b0;
  logic flash_req_erase = 1'b0, flash_req_cs = 1'b0, flash_miso, m0_miso, m1_miso;
  logic [FLASH_AW-1:0] flash_req_addr = '0, la0, la1;
  logic [7:0] flash_req_data = 8'h00, fo0, fo1, ld0, ld1, pmem_data;
  logic flash_sck, flash_mosi, boot_flash_select_n, aux_flash_select_n, init_done_o;
  logic init_done_oe, pmem_we, flash_req_ready, host_access_open, init_late;
  logic [PMEM_AW-1:0] pmem_addr;
  int c0 [0:5], c1 [0:5], pmem_cnt, error_cnt = 0, n_compared = 0;
  // External pull-up holds the released line high
  wire init_line = init_done_oe ? init_done_o : 1'b1;
  assign flash_miso = boot_flash_select_n ? m1_miso : m0_miso;

  always #5 core_clk = ~core_clk;

  fbis_boot_ctrl #(.INIT_LIMIT_CYC(400000)) dut_u (.*);
  fbis_flash_model boot_u (.rst_n(rst_n), .sck(flash_sck), .mosi(flash_mosi),
    .cs_n(boot_flash_select_n), .miso(m0_miso), .cnt(c0), .first_op(fo0),
    .last_data(ld0), .last_addr(la0));
  fbis_flash_model aux_u (.rst_n(rst_n), .sck(flash_sck), .mosi(flash_mosi),
    .cs_n(aux_flash_select_n), .miso(m1_miso), .cnt(c1), .first_op(fo1),
    .last_data(ld1), .last_addr(la1));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic wait_hi(ref logic s, input int max);
    for (int i = 0; i < max; i++)
    begin
      if (s === 1'b1)
        return;
      @(negedge core_clk);
    end
    error_cnt++;
    $display("[FAIL] %0t wait limit reached", $time);
    final_report();
  endtask : wait_hi

  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      pmem_cnt <= 0;
    else if (pmem_we)
    begin
      chk(pmem_data, pmem_addr[7:0] ^ {4'h0, pmem_addr[11:8]} ^ 8'h5A, "pmem");
      pmem_cnt <= pmem_cnt + 1;
    end

  task automatic t_reset_mid;
    repeat (2000) @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    chk({init_line, boot_flash_select_n, aux_flash_select_n, flash_sck}, 4'hE, "rst");
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : t_reset_mid

  task automatic t_boot;
    wait_hi(init_done_oe, 60000);
    @(negedge core_clk);
    chk(pmem_cnt, int'(BOOT_LAST) + 1, "copied bytes");
    chk(fo0, WRITE_ENABLE_CMD, "first op");
    chk(c0[1] >= 2, 1, "polls");
    chk(c0[2], 1, "status writes");
    chk(ld0, STATUS_CLEAR, "status value");
    chk(c1[0] + c1[1], 0, "aux idle in boot");
    chk(c0[5], 0, "link faults");
    chk({init_line, init_done_o, host_access_open}, 3'h6, "line high");
  endtask : t_boot

  task automatic t_request(input logic cs, input logic er, input logic [23:0] a,
                           input logic [7:0] d);
    int w [0:5];
    int n [0:5];
    wait_hi(flash_req_ready, 100);
    w = cs ? c1 : c0;
    {flash_req, flash_req_cs, flash_req_erase, flash_req_addr, flash_req_data} = {1'b1, cs, er, a, d};
    @(negedge core_clk);
    flash_req = 1'b0;
    chk(flash_req_ready, 1'b0, "ready drop");
    wait_hi(flash_req_ready, 20000);
    n = cs ? c1 : c0;
    chk(n[er ? 4 : 3] - w[er ? 4 : 3], 1, "op count");
    chk(n[0] - w[0], 1, "write_enable_cmd before op");
    chk(n[5], 0, "op without latch");
    chk(cs ? la1 : la0, a, "op address");
    if (!er)
      chk(cs ? ld1 : ld0, d, "op data");
  endtask : t_request

  task automatic t_init_done;
    int w0;
    w0 = c0[0] + c1[0];
    @(negedge core_clk);
    auto_init_done = 1'b1;
    flash_req = 1'b1;
    @(negedge core_clk);
    auto_init_done = 1'b0;
    flash_req = 1'b0;
    @(negedge core_clk);
    chk({init_line, init_done_oe, host_access_open}, 3'h3, "init done");
    repeat (50) @(negedge core_clk);
    chk(c0[0] + c1[0] - w0, 0, "dropped request");
    chk(init_late, 1'b0, "late flag");
  endtask : t_init_done

  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset_mid();
    t_boot();
    t_request(1'b1, 1'b0, 24'h00_0100, 8'hA5);
    t_request(1'b0, 1'b1, 24'hFF_FFFF, 8'h00);
    t_init_done();
    final_report();
  end
endmodule : tb_flash_boot_and_init_signal
